/* File: src/soe_pkg.sv */
package soe_pkg;
    // ------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W   = 22;
    localparam int unsigned IDX_LVL0 = 32'h000f_0128;
    localparam int unsigned IDX_EN0  = 32'h000f_012a;
    localparam int unsigned IDX_INV0 = 32'h000f_0134;
    localparam int unsigned IDX_LVL1 = 32'h000f_0168;
    localparam int unsigned IDX_EN1  = 32'h000f_016a;
    localparam int unsigned IDX_PIN  = 32'h000f_0180;

    localparam logic [ADDR_W-1:0] ADDR_LVL0 = ADDR_W'(IDX_LVL0 * 4);
    localparam logic [ADDR_W-1:0] ADDR_EN0  = ADDR_W'(IDX_EN0 * 4);
    localparam logic [ADDR_W-1:0] ADDR_INV0 = ADDR_W'(IDX_INV0 * 4);
    localparam logic [ADDR_W-1:0] ADDR_LVL1 = ADDR_W'(IDX_LVL1 * 4);
    localparam logic [ADDR_W-1:0] ADDR_EN1  = ADDR_W'(IDX_EN1 * 4);
    localparam logic [ADDR_W-1:0] ADDR_PIN  = ADDR_W'(IDX_PIN * 4);

    // ------------------------------------------------------------
    // Reset values and masks
    // ------------------------------------------------------------
    localparam logic [15:0] LVL0_RST  = 16'h0f0f;
    localparam logic [15:0] LVL0_MASK = 16'h0f0f;
    localparam logic [15:0] INV0_RST  = 16'h0000;
    localparam logic [2:0]  EN0_RST   = 3'h0;
    localparam logic [2:0]  EN1_RST   = 3'h0;
    localparam logic [2:0]  EN1_MASK  = 3'h5;
    localparam logic [2:0]  LVL1_RST  = 3'h7;
    localparam logic [5:0]  PIN_RST   = 6'h00;

    // Pin control field positions
    localparam int unsigned PIN_LATCH_LSB = 0;
    localparam int unsigned PIN_OD_LSB    = 8;
    localparam int unsigned PIN_DIR_LSB   = 16;
endpackage

/* File: src/soe_ctrl.sv */
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/10ps
//
// Behaviour
// - Enable bit routes engine output to pin
// - Enabled channel ignores software level writes
// - Stopped channel drives software-written level bit
// - Reset clears enable registers to zero
// - Byte-lane writes up to 24 bits (pin register), low byte writable alone
// - Unit0 channels 0-2, unit1 channels 0,2
// - Pins are input, high impedance after reset
// - Open-drain output high leaves pin undriven
//
module soe_ctrl (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    // Avalon-MM slave
    input  wire logic [21:0] avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Communication engine outputs
    input  wire logic [2:0]  comm_data_u0_i,
    input  wire logic [2:0]  comm_data_u1_i,
    // Serial data pins: u0 ch0-2, then u1 ch0-2
    output logic      [5:0]  sdo_o,
    output logic      [5:0]  sdo_oe_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] lvl0;
        logic [2:0]  en0;
        logic [15:0] inv0;
        logic [2:0]  lvl1;
        logic [2:0]  en1;
        logic [5:0]  latch;
        logic [5:0]  od;
        logic [5:0]  dir;
        logic        ack;
        logic [31:0] rdata;
        logic [5:0]  sdo;
        logic [5:0]  sdo_oe;
    } soe_state_t;

    soe_state_t st_r;
    soe_state_t st_nxt;

    logic        req;
    logic        wr;
    logic        ser;
    logic        val;
    logic [15:0] lv;
    logic [5:0]  cur_val;

    assign req = avs_read_i | avs_write_i;
    // Write lands only on the edge where waitrequest is seen low
    assign wr  = avs_write_i & st_r.ack;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt       = st_r;
        lv           = st_r.lvl0;
        ser          = 1'b0;
        val          = 1'b0;
        st_nxt.ack   = req & ~st_r.ack;

        if (wr && avs_address_i == soe_pkg::ADDR_EN0 && avs_byteenable_i[0]) begin
            st_nxt.en0 = avs_writedata_i[2:0];
        end
        // Unit 1 has no channel 1; its enable bit is forced low
        if (wr && avs_address_i == soe_pkg::ADDR_EN1 && avs_byteenable_i[0]) begin
            st_nxt.en1 = avs_writedata_i[2:0] & soe_pkg::EN1_MASK;
        end
        if (wr && avs_address_i == soe_pkg::ADDR_INV0) begin
            if (avs_byteenable_i[0]) begin
                st_nxt.inv0[7:0] = avs_writedata_i[7:0];
            end
            if (avs_byteenable_i[1]) begin
                st_nxt.inv0[15:8] = avs_writedata_i[15:8];
            end
        end
        if (wr && avs_address_i == soe_pkg::ADDR_LVL0) begin
            if (avs_byteenable_i[0]) begin
                lv[7:0] = avs_writedata_i[7:0];
            end
            if (avs_byteenable_i[1]) begin
                lv[15:8] = avs_writedata_i[15:8];
            end
        end
        // Mask keeps level bits 4-7 and 12-15 reading as zero
        st_nxt.lvl0 = lv & soe_pkg::LVL0_MASK;
        if (wr && avs_address_i == soe_pkg::ADDR_LVL1 && avs_byteenable_i[0]) begin
            st_nxt.lvl1 = avs_writedata_i[2:0];
        end
        // Engine owns the level bit while enabled; software write lost
        for (int i = 0; i < 3; i++) begin
            if (st_r.en0[i]) begin
                st_nxt.lvl0[i] = comm_data_u0_i[i];
            end
            if (st_r.en1[i]) begin
                st_nxt.lvl1[i] = comm_data_u1_i[i];
            end
        end
        if (wr && avs_address_i == soe_pkg::ADDR_PIN) begin
            if (avs_byteenable_i[0]) begin
                st_nxt.latch = avs_writedata_i[soe_pkg::PIN_LATCH_LSB +: 6];
            end
            if (avs_byteenable_i[1]) begin
                st_nxt.od = avs_writedata_i[soe_pkg::PIN_OD_LSB +: 6];
            end
            if (avs_byteenable_i[2]) begin
                st_nxt.dir = avs_writedata_i[soe_pkg::PIN_DIR_LSB +: 6];
            end
        end

        // Read data captured at the first request edge, held to the answer
        if (req && !st_r.ack) begin
            case (avs_address_i)
                soe_pkg::ADDR_LVL0: st_nxt.rdata = {16'h0000, st_r.lvl0};
                soe_pkg::ADDR_EN0:  st_nxt.rdata = {29'h0000_0000, st_r.en0};
                soe_pkg::ADDR_INV0: st_nxt.rdata = {16'h0000, st_r.inv0};
                soe_pkg::ADDR_LVL1: st_nxt.rdata = {29'h0000_0000, st_r.lvl1};
                soe_pkg::ADDR_EN1:  st_nxt.rdata = {29'h0000_0000, st_r.en1};
                soe_pkg::ADDR_PIN:  st_nxt.rdata = {10'h000, st_r.dir, 2'h0, st_r.od,
                                                    2'h0, st_r.latch};
                default:            st_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // Pin drive from the new state so pins follow registers at once
        for (int p = 0; p < 6; p++) begin
            if (p < 3) begin
                ser = st_nxt.lvl0[p] ^ st_nxt.inv0[p];
            end else begin
                ser = st_nxt.lvl1[p-3];
            end
            val = st_nxt.latch[p] & ser;
            if (!st_nxt.dir[p]) begin
                st_nxt.sdo[p]    = 1'b0;
                st_nxt.sdo_oe[p] = 1'b0;
            end else if (st_nxt.od[p]) begin
                // Released when high; the external pull-up sets the level
                st_nxt.sdo[p]    = 1'b0;
                st_nxt.sdo_oe[p] = ~val;
            end else begin
                st_nxt.sdo[p]    = val;
                st_nxt.sdo_oe[p] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            st_r        <= '0;
            st_r.lvl0   <= soe_pkg::LVL0_RST;
            st_r.inv0   <= soe_pkg::INV0_RST;
            st_r.en0    <= soe_pkg::EN0_RST;
            st_r.en1    <= soe_pkg::EN1_RST;
            st_r.lvl1   <= soe_pkg::LVL1_RST;
            st_r.latch  <= soe_pkg::PIN_RST;
            st_r.od     <= soe_pkg::PIN_RST;
            st_r.dir    <= soe_pkg::PIN_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign avs_readdata_o    = st_r.rdata;
    assign avs_waitrequest_o = ~st_r.ack;
    assign sdo_o             = st_r.sdo;
    assign sdo_oe_o          = st_r.sdo_oe;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    always_comb begin
        for (int p = 0; p < 6; p++) begin
            if (p < 3) begin
                cur_val[p] = st_r.latch[p] & (st_r.lvl0[p] ^ st_r.inv0[p]);
            end else begin
                cur_val[p] = st_r.latch[p] & st_r.lvl1[p-3];
            end
        end
    end

    AST_EN_ROUTE: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        st_r.en0[1] |=> st_r.lvl0[1] == $past(comm_data_u0_i[1]))
        else $error("enabled channel level not following engine");

    AST_WR_IGNORED: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (wr && avs_address_i == soe_pkg::ADDR_LVL0 && st_r.en0[0])
        |=> st_r.lvl0[0] == $past(comm_data_u0_i[0]))
        else $error("software write changed an enabled level bit");

    AST_SW_LEVEL: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (wr && avs_address_i == soe_pkg::ADDR_LVL0 && avs_byteenable_i[0] && !st_r.en0[2])
        |=> st_r.lvl0[2] == $past(avs_writedata_i[2]))
        else $error("stopped channel level bit not written");

    // Reset checks follow reset_i itself, so they carry no disable
    AST_RESET_CLEAR: assert property (
        @(posedge mclk_i)
        reset_i |=> (st_r.en0 == 3'h0 && st_r.en1 == 3'h0))
        else $error("enable registers not cleared by reset");

    AST_BYTE_LANE: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (wr && avs_address_i == soe_pkg::ADDR_EN0 && !avs_byteenable_i[0])
        |=> $stable(st_r.en0))
        else $error("enable changed without low byte lane");

    AST_U1_NOCH1: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        !st_r.en1[1])
        else $error("unit1 channel 1 enable present");

    // Read data is judged only at the answer edge; it stands stale otherwise
    AST_U1_READ: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (avs_read_i && !avs_waitrequest_o && avs_address_i == soe_pkg::ADDR_EN1)
        |-> (avs_readdata_o[31:3] == 29'h0000_0000 && !avs_readdata_o[1]))
        else $error("unit1 enable read shows unused bits");

    AST_EN0_RESV: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (avs_read_i && !avs_waitrequest_o && avs_address_i == soe_pkg::ADDR_EN0)
        |-> avs_readdata_o[31:3] == 29'h0000_0000)
        else $error("unit0 enable read shows unused bits");

    AST_EN1_LANE: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (wr && avs_address_i == soe_pkg::ADDR_EN1 && !avs_byteenable_i[0])
        |=> $stable(st_r.en1))
        else $error("unit1 enable changed without low byte lane");

    AST_HIZ_RESET: assert property (
        @(posedge mclk_i)
        reset_i |=> sdo_oe_o == 6'h00)
        else $error("pin driven after reset");

    AST_OD_RELEASE: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (st_r.od[0] && st_r.dir[0] && cur_val[0]) |-> !sdo_oe_o[0])
        else $error("open-drain pin driven while high");

    AST_ANSWER: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (req && avs_waitrequest_o) |=> !avs_waitrequest_o)
        else $error("request not answered in one cycle");

    AST_WR_ACK: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (req && !avs_waitrequest_o) |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");

    AST_STOP_HOLD: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (!st_r.en0[0] && !(wr && avs_address_i == soe_pkg::ADDR_LVL0))
        |=> $stable(st_r.lvl0[0]))
        else $error("stopped channel level moved without a write");

    AST_U1_ROUTE: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        st_r.en1[2] |=> st_r.lvl1[2] == $past(comm_data_u1_i[2]))
        else $error("unit1 enabled channel level not following engine");

    AST_U1_STOP_HOLD: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (!st_r.en1[0] && !(wr && avs_address_i == soe_pkg::ADDR_LVL1))
        |=> $stable(st_r.lvl1[0]))
        else $error("unit1 stopped channel level moved without a write");

    // Pin drive against the register state
    AST_PP_DRIVE: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (st_r.dir[3] && !st_r.od[3])
        |-> (sdo_oe_o[3] && sdo_o[3] == cur_val[3]))
        else $error("push-pull pin not driving its level");

    AST_DIR_IN: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        !st_r.dir[5] |-> !sdo_oe_o[5])
        else $error("input-mode pin driven");

    AST_OD_LOW: assert property (
        @(posedge mclk_i) disable iff (reset_i)
        (st_r.od[1] && st_r.dir[1] && !cur_val[1])
        |-> (sdo_oe_o[1] && !sdo_o[1]))
        else $error("open-drain pin not pulling low");

endmodule

/* File: tb/soe_peer.sv */
`timescale 1ns/10ps
// ------------------------------------------------------------
// Far-side serial peer with bus pull-ups
// ------------------------------------------------------------
module soe_peer (
    // Pin drive from the block
    input  wire logic [5:0] sdo_i,
    input  wire logic [5:0] oe_i,
    // Resolved wire level
    output logic      [5:0] line_o
);
    // Released line floats to the pull-up level, never the last value
    always_comb begin
        for (int k = 0; k < 6; k++) begin
            line_o[k] = oe_i[k] ? sdo_i[k] : 1'b1;
        end
    end
endmodule

/* File: tb/tb.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb;
    logic        mclk_i = 0, reset_i = 1, rd = 0, wr = 0, wreq;
    logic [21:0] addr = '0;
    logic [31:0] wd = '0, rdata, seed = 32'h6b8c_29ef, r, rw;
    logic [3:0]  be = '0;
    logic [2:0]  c0 = '0, c1 = '0;
    logic [5:0]  sdo, oe, line, v;
    logic [21:0] ra[7];
    logic [31:0] msk[7], m[7];
    int          mismatches = 0, check_count = 0, i;

    soe_ctrl u_soe_ctrl (.mclk_i(mclk_i), .reset_i(reset_i), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .comm_data_u0_i(c0),
        .comm_data_u1_i(c1), .sdo_o(sdo), .sdo_oe_o(oe));
    soe_peer u_soe_peer (.sdo_i(sdo), .oe_i(oe), .line_o(line));

    initial forever #4 mclk_i = ~mclk_i;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic stop_test();
        $display("mismatches %0d checks %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Bus master and model
    // ------------------------------------------------------------
    task automatic bus(input logic w, input int k, input logic [31:0] d, input logic [3:0] b);
        int          n;
        logic [31:0] lm;
        n = 0;
        lm = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
        @(posedge mclk_i);
        rd   <= !w;
        wr   <= w;
        addr <= ra[k];
        wd   <= d;
        be   <= b;
        // Held until waitrequest is sampled low; only the watchdog ends a hang
        do begin
            @(posedge mclk_i);
            n++;
        end while (wreq !== 1'b0);
        `CHK("answer_edges", 2, n)
        rd <= 0;
        wr <= 0;
        if (w && k < 6) m[k] = ((m[k] & ~lm) | (d & lm)) & msk[k];
        if (!w) `CHK("readback", m[k], rdata & msk[k])
    endtask

    // Enabled channels: level bit follows the engine
    task automatic settle();
        repeat (3) @(posedge mclk_i);
        for (int k = 0; k < 3; k++) begin
            if (m[1][k]) m[0][k] = c0[k];
            if (m[4][k]) m[3][k] = c1[k];
        end
    endtask

    task automatic chkpins();
        settle();
        v = {m[3][2:0], m[0][2:0] ^ m[2][2:0]} & m[5][5:0];
        `CHK("pin_oe", m[5][21:16] & (~m[5][13:8] | ~v), oe)
        `CHK("pin_level", ~m[5][21:16] | v, line)
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        ra = '{soe_pkg::ADDR_LVL0, soe_pkg::ADDR_EN0, soe_pkg::ADDR_INV0, soe_pkg::ADDR_LVL1,
               soe_pkg::ADDR_EN1, soe_pkg::ADDR_PIN, 22'h3c_0700};
        msk = '{32'h0f0f, 32'h7, 32'h7, 32'h7, 32'h5, 32'h3f_3f3f, '1};
        m = '{32'h0f0f, 0, 0, 32'h7, 0, 0, 0};
        repeat (6) @(posedge mclk_i);
        reset_i <= 0;
        chkpins();
        for (int k = 0; k < 7; k++) bus(0, k, 0, 4'h0);
        // Two-wire preparation: latch, open-drain, direction, then enable
        bus(1, 5, 32'h1, 4'h1);
        chkpins();
        bus(1, 5, 32'h101, 4'h2);
        chkpins();
        bus(1, 5, 32'h1_0101, 4'h4);
        chkpins();
        c0 <= 3'h1;
        bus(1, 1, 32'h1, 4'h1);
        chkpins();
        for (int k = 0; k < 80; k++) begin
            r = rnd();
            c0 <= r[2:0];
            c1 <= r[5:3];
            i = int'(r[10:8]) % 7;
            settle();
            rw = rnd() & ((i == 1) ? 32'h7 : (i == 4) ? 32'h5 : '1);
            bus(1, i, rw, r[15:12]);
            chkpins();
            bus(0, i, 0, 4'h0);
        end
        // Mid-run reset with channels enabled: all must come back to reset values
        bus(1, 1, 32'h7, 4'h1);
        bus(1, 4, 32'h5, 4'h1);
        reset_i <= 1;
        repeat (6) @(posedge mclk_i);
        reset_i <= 0;
        m = '{32'h0f0f, 0, 0, 32'h7, 0, 0, 0};
        chkpins();
        for (int k = 0; k < 7; k++) bus(0, k, 0, 4'h0);
        stop_test();
    end

    initial begin
        #100_000;
        mismatches++;
        stop_test();
    end
endmodule
